// File: bpc_cfg.svh
/*
  Constants for the boost power-factor current-loop controller.
  Assumes a 125 MHz system clock and sense converters that deliver
  signed samples in millivolts (current amplifier output) and
  unsigned codes (line, bulk voltage).
*/
// Operation
// - Zero commanded duty keeps the gate low for the whole switching period.
// - The duty bound lets the gate reach at least 92 percent of a period.
// - The duty bound is fixed inside the modulator, independent of inputs.
// - Second comparator trips when current amplifier output reaches 850 mV.
// - A trip ends the ongoing gate pulse at once.
// - A trip holds the stage off for one second, then restarts it.
// - Soft start computes charge current for about 50 ms at 0.8 uF per watt.
// - The stage starts with that soft-start current, capped at 225 mV, as demand limit.
// - Demand is voltage-loop output times rectified line difference.
// - Demand is clamped so averaged sense voltage stays within -225 mV.
// - The current loop regulates the amplifier average to 450 mV.
// - Filtered amplifier average is subtracted from the ramp and sent to a DAC.
// - The cycle ends when ramp and amplifier signal meet at the comparator.
// - The voltage loop stays stable for 0.5 to 2.4 uF per watt.
`ifndef BPC_CFG_SVH
`define BPC_CFG_SVH

`define BPC_CLK_MHZ       125
`define BPC_PERIOD_NS     10000
`define BPC_PERIOD_CYC    ((`BPC_PERIOD_NS * `BPC_CLK_MHZ) / 1000)
`define BPC_DUTY_MAX_PCT  92
`define BPC_DUTY_MAX_CYC  ((`BPC_PERIOD_CYC * `BPC_DUTY_MAX_PCT + 99) / 100)
`define BPC_OCP_MV        16'sh0352
`define BPC_EQ_MV         16'sh01C2
`define BPC_CS_LIM_MV     16'sh00E1
`define BPC_HOLD_MS       1000
`define BPC_HOLD_CYC      (`BPC_HOLD_MS * `BPC_CLK_MHZ * 1000)
`define BPC_SS_MS         50
`define BPC_SS_UF_PER_W_X10 8
`define BPC_VREF          16'h0FA0
`define BPC_VLOOP_SHIFT   4
`define BPC_FILT_SHIFT    3
`define BPC_DEM_SHIFT     12

`endif

// File: bpc_pkg.sv
/*
  Types for the boost power-factor current-loop controller.
  Assumes the constants header is included by the design file.
*/
package bpc_pkg;
  typedef enum logic [2:0] {
    BPC_IDLE  = 3'b001,
    BPC_RUN   = 3'b010,
    BPC_HOLD  = 3'b100
  } bpc_state_t;
endpackage

// File: bpc_ctrl.sv
/*
  Boost PFC current-loop control: demand, ramp offset, PWM, second limit.
  Assumes sample inputs are on clk; the comparator trip input is an
  asynchronous pin and is synchronised here.
*/
`include "bpc_cfg.svh"

module bpc_ctrl
  import bpc_pkg::*;
  #(parameter int HOLD_CYC = `BPC_HOLD_CYC)
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Sense converter samples.
  input  wire logic [15:0] line_sense_pos,
  input  wire logic [15:0] line_sense_neg,
  input  wire logic [15:0] bulk_sense,
  input  wire logic signed [15:0] current_amplifier_output,
  input  wire logic        sample_valid,
  input  wire logic [15:0] rated_power_w,
  input  wire logic        enable,
  // Fast comparator result pin, high while ramp exceeds amplifier.
  input  wire logic        pwm_comparator_trip,
  // Outputs.
  output logic             boost_gate_drive_output,
  output logic [15:0]      average_current_demand,
  output logic [15:0]      ramp_dac,
  output logic             stage_shutdown
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  bpc_state_t        st_reg,   st_next;
  logic [15:0]       cnt_reg,  cnt_next;
  logic              gate_reg, gate_next;
  logic [31:0]       hold_reg, hold_next;
  logic signed [31:0] vint_reg, vint_next;
  logic signed [31:0] filt_reg, filt_next;
  logic [15:0]       dem_reg,  dem_next;
  logic [15:0]       lim_reg,  lim_next;
  logic [15:0]       dac_reg,  dac_next;
  logic [1:0]        cmp_sync_reg;
  logic [15:0]       line_mag;
  logic [31:0]       prod;
  logic [31:0]       ss_cur;
  logic              ocp;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    gate_next = gate_reg;
    hold_next = hold_reg;
    vint_next = vint_reg;
    filt_next = filt_reg;
    dem_next  = dem_reg;
    lim_next  = lim_reg;
    dac_next  = dac_reg;
    line_mag  = (line_sense_pos >= line_sense_neg) ?
                line_sense_pos - line_sense_neg :
                line_sense_neg - line_sense_pos;
    ocp       = current_amplifier_output >= `BPC_OCP_MV;
    prod      = 32'(vint_reg[15:0]) * 32'(line_mag);
    ss_cur    = ((32'(`BPC_VREF) - 32'(line_mag)) * 32'(rated_power_w)
                 * 32'(`BPC_SS_UF_PER_W_X10)) / (32'(`BPC_SS_MS) * 32'd10);
    unique case (st_reg)
      BPC_IDLE:
      begin
        gate_next = 1'b0;
        if (ocp)
        begin
          hold_next = 32'(HOLD_CYC - 1);
          st_next   = BPC_HOLD;
        end
        else if (enable)
        begin
          lim_next = (ss_cur > 32'(`BPC_CS_LIM_MV)) ?
                     16'(`BPC_CS_LIM_MV) : ss_cur[15:0];
          cnt_next = 16'h0000;
          st_next  = BPC_RUN;
        end
      end
      BPC_RUN:
      begin
        cnt_next = (cnt_reg == 16'(`BPC_PERIOD_CYC - 1)) ?
                   16'h0000 : cnt_reg + 16'h0001;
        if (cnt_reg == 16'(`BPC_PERIOD_CYC - 1))
          gate_next = (dem_reg != 16'h0000) && !cmp_sync_reg[1];
        else if (cnt_reg >= 16'(`BPC_DUTY_MAX_CYC - 1))
          gate_next = 1'b0;
        else if (cmp_sync_reg[1])
          gate_next = 1'b0;
        if (sample_valid)
        begin
          vint_next = vint_reg + (($signed(32'(`BPC_VREF))
                      - $signed(32'(bulk_sense))) >>> `BPC_VLOOP_SHIFT);
          if (vint_next < 0)
            vint_next = 32'sh0;
          else if (vint_next > 32'sh0000FFFF)
            vint_next = 32'sh0000FFFF;
          dem_next = (prod[`BPC_DEM_SHIFT +: 16] > lim_reg) ?
                     lim_reg : prod[`BPC_DEM_SHIFT +: 16];
          filt_next = filt_reg + ((32'(current_amplifier_output)
                      - 32'(`BPC_EQ_MV) - filt_reg) >>> `BPC_FILT_SHIFT);
          dac_next = 16'(32'(cnt_reg) - filt_next);
        end
        if (!enable)
        begin
          gate_next = 1'b0;
          st_next   = BPC_IDLE;
        end
        if (ocp)
        begin
          gate_next = 1'b0;
          hold_next = 32'(HOLD_CYC - 1);
          st_next   = BPC_HOLD;
        end
      end
      BPC_HOLD:
      begin
        gate_next = 1'b0;
        hold_next = hold_reg - 32'h1;
        if (hold_reg == 32'h0)
          st_next = BPC_IDLE;
      end
      default:
        st_next = BPC_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg       <= BPC_IDLE;
      cnt_reg      <= 16'h0000;
      gate_reg     <= 1'b0;
      hold_reg     <= 32'h0;
      vint_reg     <= 32'sh0;
      filt_reg     <= 32'sh0;
      dem_reg      <= 16'h0000;
      lim_reg      <= 16'h0000;
      dac_reg      <= 16'h0000;
      cmp_sync_reg <= 2'b00;
    end
    else
    begin
      st_reg       <= st_next;
      cnt_reg      <= cnt_next;
      gate_reg     <= gate_next;
      hold_reg     <= hold_next;
      vint_reg     <= vint_next;
      filt_reg     <= filt_next;
      dem_reg      <= dem_next;
      lim_reg      <= lim_next;
      dac_reg      <= dac_next;
      cmp_sync_reg <= {cmp_sync_reg[0], pwm_comparator_trip};
    end
  end

  assign boost_gate_drive_output = gate_reg;
  assign average_current_demand  = dem_reg;
  assign ramp_dac                = dac_reg;
  assign stage_shutdown          = st_reg[2];

endmodule

// File: bpc_ctrl_chk.sv
/* Assertions on the ports of bpc_ctrl.
   Assumes one clock and a synchronous active-low reset. */
module bpc_ctrl_chk
  #(parameter int HOLD_CYC = 100)
(
  // Inputs.
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic [15:0]        line_sense_pos,
  input wire logic [15:0]        line_sense_neg,
  input wire logic [15:0]        bulk_sense,
  input wire logic signed [15:0] current_amplifier_output,
  input wire logic               sample_valid,
  input wire logic [15:0]        rated_power_w,
  input wire logic               enable,
  input wire logic               pwm_comparator_trip,
  // Outputs.
  input wire logic               boost_gate_drive_output,
  input wire logic [15:0]        average_current_demand,
  input wire logic [15:0]        ramp_dac,
  input wire logic               stage_shutdown
);
  localparam int HOLD_MAX = HOLD_CYC + 20;
  logic [11:0] hi_reg;
  logic [11:0] hi_next;
  always_comb hi_next = boost_gate_drive_output ? hi_reg + 12'h001 : 12'h000;
  always_ff @(posedge clk) hi_reg <= rst_n ? hi_next : 12'h000;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  duty_bound_a: assert property (hi_reg <= 12'h47E)
    else $error("gate high beyond duty bound");
  ocp_cut_a: assert property (current_amplifier_output >= 16'sh0352
    |=> !boost_gate_drive_output) else $error("gate not cut on trip");
  ocp_hold_a: assert property (current_amplifier_output >= 16'sh0352
    |=> stage_shutdown) else $error("no shutdown on trip");
  hold_gate_a: assert property (stage_shutdown
    |-> !boost_gate_drive_output) else $error("gate during hold");
  hold_end_a: assert property ($rose(stage_shutdown)
    |-> ##[1:HOLD_MAX] !stage_shutdown) else $error("hold never ends");
  zero_duty_a: assert property ($rose(boost_gate_drive_output)
    |-> $past(average_current_demand) != 16'h0000)
    else $error("pulse at zero");
  demand_clamp_a: assert property (average_current_demand <= 16'h00E1)
    else $error("demand above clamp");
  cmp_end_a: assert property (pwm_comparator_trip[*3]
    |=> !boost_gate_drive_output) else $error("cycle not ended");
  c_pulse: cover property ($fell(boost_gate_drive_output));
  c_hold: cover property ($fell(stage_shutdown));
  c_trip: cover property (pwm_comparator_trip[*3]);
endmodule
bind bpc_ctrl bpc_ctrl_chk #(.HOLD_CYC(HOLD_CYC)) u_bpc_ctrl_chk (.*);

// File: bpc_sense_model.sv
/* Sense converter and comparator model.
   Assumes the bench raises ocp_req and trip_req. */
module bpc_sense_model
(
  input wire logic           clk,
  input wire logic           gate,
  input wire logic           ocp_req,
  input wire logic           trip_req,
  output logic signed [15:0] cao,
  output logic               valid,
  output logic               trip
);
  logic [6:0] cnt = 7'h00;
  initial {cao, valid, trip} = '0;
  always @(posedge clk)
  begin
    cnt <= cnt + 7'h01;
    valid <= (cnt == 7'h00);
    trip <= trip_req;
    cao <= ocp_req ? 16'sh0384 : (gate ? 16'sh01B8 : 16'sh01C2);
  end
endmodule

// File: bpc_ctrl_tb.sv
/* Self-checking bench for bpc_ctrl.
   Assumes a 125 MHz clock and a shortened hold. */
module bpc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED %0t mismatch", $time); end end
  localparam int HOLD = 100;
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, ocp = 1'b0, trq = 1'b0;
  logic [15:0] pos = 16'h0000, neg = 16'h0000, dem, ramp;
  logic signed [15:0] cao;
  logic vld, trip, gate, shut;
  int err_count = 0, cmp_count = 0, seed = 32'h5e7f, hi = 0, n, v;
  int mst = 0, vi = 0, mf = 0, mcnt = 0, edem = 0, edac = 0, mag = 0;
  always #4 clk = ~clk;
  // Reference model of state, voltage loop, demand, filter and ramp.
  always @(posedge clk)
  begin
    if (rst_n !== 1'b1)
    begin
      mst = 0;
      vi = 0;
      mf = 0;
      edem = 0;
      edac = 0;
    end
    else if (mst == 1)
    begin
      if (vld === 1'b1)
      begin
        mag = (pos >= neg) ? pos - neg : neg - pos;
        edem = (vi * mag) >>> 12;
        if (edem > 225)
          edem = 225;
        vi = vi + ((4000 - 2048) >>> 4);
        if (vi > 65535)
          vi = 65535;
        mf = mf + ((cao - 450 - mf) >>> 3);
        edac = (mcnt - mf) & 32'hFFFF;
      end
      mcnt = (mcnt == 1249) ? 0 : mcnt + 1;
      if (cao >= 850)
        mst = 2;
      else if (en !== 1'b1)
        mst = 0;
    end
    else if (mst == 2 && shut === 1'b1)
      mst = 2;
    else if (cao >= 850)
      mst = 2;
    else if (en === 1'b1)
    begin
      mst = 1;
      mcnt = 0;
    end
    else
      mst = 0;
  end
  bpc_ctrl #(.HOLD_CYC(HOLD)) u_bpc_ctrl (.clk(clk), .rst_n(rst_n),
    .line_sense_pos(pos), .line_sense_neg(neg), .bulk_sense(16'h0800),
    .current_amplifier_output(cao), .sample_valid(vld),
    .rated_power_w(16'h012C), .enable(en), .pwm_comparator_trip(trip),
    .boost_gate_drive_output(gate), .average_current_demand(dem),
    .ramp_dac(ramp), .stage_shutdown(shut));
  bpc_sense_model u_bpc_sense_model (.clk(clk), .gate(gate), .ocp_req(ocp),
    .trip_req(trq), .cao(cao), .valid(vld), .trip(trip));
  task automatic run(input int cyc, input bit zero);
    repeat (cyc)
    begin
      @(posedge clk);
      v = $random(seed) & 32'h3FF;
      pos <= 16'(v);
      neg <= zero ? 16'(v) : 16'h0000;
      #1 hi = (gate === 1'b1) ? hi + 1 : 0;
      `CHK(hi > 1150, 1'b0)
      `CHK(dem > 16'h00E1, 1'b0)
      `CHK(dem, 16'(edem))
      `CHK(ramp, 16'(edac))
      if (zero) `CHK(gate, 1'b0)
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    en <= 1'b1;
    #1 `CHK({gate, shut}, 2'b00)
    run(2600, 1'b1);
    run(3800, 1'b0);
    @(posedge clk) ocp <= 1'b1;
    @(posedge clk) ocp <= 1'b0;
    n = 0;
    while (shut !== 1'b1 && n < 10) begin @(posedge clk); #1 n++; end
    `CHK({shut, gate}, 2'b10)
    n = 0;
    while (shut === 1'b1 && n < 1000) begin @(posedge clk); #1 n++; end
    `CHK(n >= HOLD && n < 1000, 1'b1)
    run(1300, 1'b0);
    @(posedge clk) trq <= 1'b1;
    repeat (4) @(posedge clk);
    #1 `CHK(gate, 1'b0)
    trq <= 1'b0;
    conclude();
  end
endmodule
